/* File: core/psw_top.sv */
// Power-state supervisor: sleep/normal tracking, power-on reset, serial registers,
// self-test of the status register and watchdog driving the MCU reset pin.
// Assumes all pin inputs are asynchronous to clock and are synchronised here.
module psw_top
  import psw_pkg::*;
#(
  parameter int unsigned TICK_CYC  = WD_TICK_CYC,
  parameter int unsigned PULSE_CYC = RESET_PULSE_CYC
) (
  // Clock and reset
  input  wire logic        clock,
  input  wire logic        rst_n,
  // Power pins
  input  wire logic        keySwitchInput,
  input  wire logic        vccUndervoltage,
  input  wire logic        mainSupplyOvervoltage,
  // Serial port
  input  wire logic        spiClk,
  input  wire logic        spiCsN,
  input  wire logic        spiDataIn,
  output logic             spiDataOut,
  output logic             spiDataOutOe,
  // Output requests and faults
  input  wire logic [7:0]  parallelInput,
  input  wire logic [6:0]  faultInput,
  // Driven outputs
  output logic [7:0]       outputEnable,
  output psw_supply_t      supplyEnable,
  output logic             batterySwitchOutput,
  output logic             openLoadSinkEnable,
  // MCU reset, open drain
  output logic             mcuResetOutput,
  output logic             mcuResetOutputOe
);

  // ==========================================================================
  // Reset release and input synchronisers
  // ==========================================================================
  logic rstMeta;
  logic rstN;

  always_ff @(posedge clock or negedge rst_n) begin
    if (!rst_n) begin
      rstMeta <= 1'b0;
      rstN    <= 1'b0;
    end else begin
      rstMeta <= 1'b1;
      rstN    <= rstMeta;
    end
  end

  logic [20:0] pinMeta;
  logic [20:0] pinSync;
  logic        keyS;
  logic        sclkS;
  logic        csNS;
  logic        siS;
  logic        vccUvS;
  logic        vpwrOvS;
  logic [7:0]  parS;
  logic [6:0]  faultS;

  always_ff @(posedge clock or negedge rstN) begin
    if (!rstN) begin
      pinMeta <= 21'h000004;
      pinSync <= 21'h000004;
    end else begin
      pinMeta <= {faultInput, parallelInput, mainSupplyOvervoltage, vccUndervoltage,
                  keySwitchInput, spiCsN, spiClk, spiDataIn};
      pinSync <= pinMeta;
    end
  end

  assign {faultS, parS, vpwrOvS, vccUvS, keyS, csNS, sclkS, siS} = pinSync;

  // ==========================================================================
  // Power state machine
  // ==========================================================================
  psw_state_t  state;
  logic [15:0] qualCnt;
  logic        porPulse;
  logic [7:0]  ctrl1;
  logic        powerHold;

  assign powerHold = ctrl1[CTRL1_POWER_HOLD_BIT];

  always_ff @(posedge clock or negedge rstN) begin
    if (!rstN) begin
      state    <= PSW_SLEEP;
      qualCnt  <= 16'h0000;
      porPulse <= 1'b0;
    end else begin
      porPulse <= 1'b0;
      unique case (state)
        PSW_SLEEP: begin
          qualCnt <= 16'h0000;
          if (keyS) begin
            state <= PSW_QUALIFY;
          end
        end
        PSW_QUALIFY: begin
          if (!keyS) begin
            state <= PSW_SLEEP;
          end else if (qualCnt == 16'(POR_QUAL_CYC - 1)) begin
            state    <= PSW_NORMAL;
            porPulse <= 1'b1;
          end else begin
            qualCnt <= qualCnt + 16'h0001;
          end
        end
        PSW_NORMAL: begin
          if (!keyS) begin
            state <= powerHold ? PSW_SHUTDOWN : PSW_SLEEP;
          end
        end
        PSW_SHUTDOWN: begin
          if (keyS) begin
            state <= PSW_NORMAL;
          end else if (!powerHold) begin
            state <= PSW_SLEEP;
          end
        end
      endcase
    end
  end

  // ==========================================================================
  // Serial slave: 16-bit frames, write flag, 7-bit index, 8-bit data
  // ==========================================================================
  logic        sclkPrev;
  logic        csNPrev;
  logic [15:0] shiftIn;
  logic [15:0] shiftOut;
  logic [15:0] respWord;
  logic [4:0]  bitCnt;
  psw_frame_t  frame;
  logic        frameValid;
  logic        spiErr;
  logic [7:0]  readData;
  logic        wrStrobe;

  assign frame    = psw_frame_t'(shiftIn);
  assign wrStrobe = frameValid && frame.wr;

  always_ff @(posedge clock or negedge rstN) begin
    if (!rstN) begin
      sclkPrev     <= 1'b0;
      csNPrev      <= 1'b1;
      shiftIn      <= 16'h0000;
      shiftOut     <= 16'h0000;
      bitCnt       <= 5'h00;
      spiDataOut   <= 1'b0;
      spiDataOutOe <= 1'b0;
    end else begin
      sclkPrev     <= sclkS;
      csNPrev      <= csNS;
      spiDataOutOe <= !csNS;
      if (csNPrev && !csNS) begin
        bitCnt     <= 5'h00;
        shiftOut   <= respWord;
        spiDataOut <= respWord[15];
      end else if (!csNS && !sclkPrev && sclkS) begin
        shiftIn <= {shiftIn[14:0], siS};
        if (bitCnt != 5'h1f) begin
          bitCnt <= bitCnt + 5'h01;
        end
      end else if (!csNS && sclkPrev && !sclkS) begin
        shiftOut   <= {shiftOut[14:0], 1'b0};
        spiDataOut <= shiftOut[14];
      end
    end
  end

  always_ff @(posedge clock or negedge rstN) begin
    if (!rstN) begin
      frameValid <= 1'b0;
      spiErr     <= 1'b0;
    end else begin
      frameValid <= 1'b0;
      spiErr     <= 1'b0;
      if (!csNPrev && csNS) begin
        if (bitCnt == 5'(FRAME_BITS) && addr_ok(shiftIn[14:8])) begin
          frameValid <= 1'b1;
        end else begin
          spiErr <= 1'b1;
        end
      end
    end
  end

  // ==========================================================================
  // Reset pulse generator and register default strobes
  // ==========================================================================
  logic        resetActive;
  logic [31:0] pulseCnt;
  logic        wdExpired;
  logic        pulseStart;
  logic        pulseEnd;
  logic        softReset;
  logic        regDefault;

  assign pulseStart = porPulse || wdExpired || vccUvS || vpwrOvS;
  assign pulseEnd   = resetActive && pulseCnt == 32'(PULSE_CYC - 1) && !pulseStart;
  assign regDefault = porPulse || softReset;

  always_ff @(posedge clock or negedge rstN) begin
    if (!rstN) begin
      resetActive <= 1'b1;
      pulseCnt    <= 32'h00000000;
    end else if (state == PSW_SLEEP || state == PSW_QUALIFY || pulseStart) begin
      resetActive <= 1'b1;
      pulseCnt    <= 32'h00000000;
    end else if (pulseEnd) begin
      resetActive <= 1'b0;
    end else if (resetActive) begin
      pulseCnt <= pulseCnt + 32'h00000001;
    end
  end

  always_ff @(posedge clock or negedge rstN) begin
    if (!rstN) begin
      softReset <= 1'b0;
    end else begin
      softReset <= wrStrobe && frame.addr == ADDR_CTRL1 &&
                   frame.data[CTRL1_SOFT_RESET_BIT];
    end
  end

  // ==========================================================================
  // Control and output registers
  // ==========================================================================
  logic [7:0] outCtrl;

  always_ff @(posedge clock or negedge rstN) begin
    if (!rstN) begin
      ctrl1 <= CTRL1_RESET;
    end else if (regDefault) begin
      ctrl1 <= CTRL1_RESET;
    end else if (pulseStart) begin
      ctrl1[CTRL1_SELF_TEST_BIT] <= 1'b0;
    end else if (wrStrobe && frame.addr == ADDR_CTRL1) begin
      ctrl1 <= frame.data;
    end
  end

  always_ff @(posedge clock or negedge rstN) begin
    if (!rstN) begin
      outCtrl <= OUT_CTRL_RESET;
    end else if (regDefault) begin
      outCtrl <= OUT_CTRL_RESET;
    end else if (wrStrobe && frame.addr == ADDR_OUT_CTRL) begin
      outCtrl <= frame.data;
    end
  end

  // ==========================================================================
  // Status register and self-test
  // ==========================================================================
  logic [7:0] status;
  logic       selfTest;
  logic       selfTestPrev;
  logic       statusWr;

  assign selfTest = ctrl1[CTRL1_SELF_TEST_BIT];
  assign statusWr = wrStrobe && frame.addr == ADDR_STATUS;

  always_ff @(posedge clock or negedge rstN) begin
    if (!rstN) begin
      selfTestPrev <= 1'b0;
      status       <= STATUS_RESET;
    end else begin
      selfTestPrev <= selfTest;
      if (regDefault || (selfTestPrev && !selfTest)) begin
        status <= STATUS_RESET;
      end else if (selfTest) begin
        if (statusWr) begin
          status <= frame.data;
        end
      end else begin
        status <= (statusWr ? (status & frame.data) : status) |
                  {spiErr, faultS};
      end
    end
  end

  // ==========================================================================
  // Watchdog registers and timer
  // ==========================================================================
  logic [7:0] wdCfg;
  logic [7:0] wdCtrl;
  logic       wdCtrlWr;
  logic       refresh;
  logic       wdReload;
  logic [6:0] tempField;
  logic [9:0] loadTicks;
  logic       tick;
  logic [31:0] tickCnt;

  assign wdCtrlWr  = wrStrobe && frame.addr == ADDR_WD_CTRL;
  assign refresh   = wdCtrlWr && frame.data[WD_REFRESH_BIT];
  assign wdReload  = refresh || pulseEnd || regDefault;
  assign tempField = (wdCtrlWr && frame.data[6:0] != 7'h00) ? frame.data[6:0] : wdCtrl[6:0];
  assign loadTicks = (tempField != 7'h00) ? wd_ticks(tempField)
                                          : wd_ticks(wdCfg[6:0]);

  always_ff @(posedge clock or negedge rstN) begin
    if (!rstN) begin
      wdCfg <= WD_CFG_RESET;
    end else if (regDefault || pulseStart) begin
      wdCfg <= WD_CFG_RESET;
    end else if (wrStrobe && frame.addr == ADDR_WD_CFG) begin
      wdCfg <= frame.data;
    end
  end

  always_ff @(posedge clock or negedge rstN) begin
    if (!rstN) begin
      wdCtrl <= WD_CTRL_RESET;
    end else if (regDefault || wdReload) begin
      wdCtrl <= WD_CTRL_RESET;
    end else if (wdCtrlWr) begin
      wdCtrl <= frame.data;
    end
  end

  always_ff @(posedge clock or negedge rstN) begin
    if (!rstN) begin
      tickCnt <= 32'h00000000;
      tick    <= 1'b0;
    end else begin
      tick <= 1'b0;
      if (wdReload || tickCnt == 32'(TICK_CYC - 1)) begin
        tickCnt <= 32'h00000000;
        tick    <= !wdReload;
      end else begin
        tickCnt <= tickCnt + 32'h00000001;
      end
    end
  end

  psw_wd_timer u_wd_timer (
    .clock     (clock),
    .rstN      (rstN),
    .tick      (tick),
    .enable    (wdCfg[WD_ENABLE_BIT] && !resetActive),
    .reload    (wdReload),
    .loadTicks (loadTicks),
    .expired   (wdExpired)
  );

  // ==========================================================================
  // Read-back for the next frame's answer
  // ==========================================================================
  always_comb begin
    readData = 8'h00;
    unique case (frame.addr)
      ADDR_CTRL1:    readData = ctrl1;
      ADDR_WD_CFG:   readData = wdCfg;
      ADDR_WD_CTRL:  readData = wdCtrl;
      ADDR_OUT_CTRL: readData = outCtrl;
      ADDR_STATUS:   readData = status;
      ADDR_SYS:      readData = {5'h00, resetActive, 2'(state)};
      default:       readData = 8'h00;
    endcase
  end

  always_ff @(posedge clock or negedge rstN) begin
    if (!rstN) begin
      respWord <= 16'h0000;
    end else if (frameValid) begin
      respWord <= {1'b0, frame.addr, readData};
    end
  end

  // ==========================================================================
  // Pin drivers
  // ==========================================================================
  always_ff @(posedge clock or negedge rstN) begin
    if (!rstN) begin
      outputEnable        <= 8'h00;
      supplyEnable        <= '0;
      batterySwitchOutput <= 1'b0;
      openLoadSinkEnable  <= 1'b0;
      mcuResetOutput      <= 1'b0;
      mcuResetOutputOe    <= 1'b1;
    end else begin
      mcuResetOutput   <= 1'b0;
      mcuResetOutputOe <= resetActive;
      if (resetActive || state == PSW_SLEEP || state == PSW_QUALIFY) begin
        outputEnable <= 8'h00;
      end else if (state == PSW_SHUTDOWN) begin
        outputEnable <= (outCtrl | parS) & RELAY2_MASK;
      end else begin
        outputEnable <= outCtrl | parS;
      end
      supplyEnable        <= (state == PSW_SLEEP) ? 3'b000 : 3'b111;
      batterySwitchOutput <= (state == PSW_NORMAL);
      openLoadSinkEnable  <= (state != PSW_SLEEP);
    end
  end

endmodule : psw_top

/* File: core/psw_pkg.sv */
// Constants, types and decode helpers for the power-state supervisor with watchdog.
// Assumes a single 100 MHz clock domain; all cycle counts derive from it here.
package psw_pkg;

  // ==========================================================================
  // Timing
  // ==========================================================================
  localparam int CLK_HZ          = 100_000_000;
  localparam int POR_QUAL_NS     = 20_000;
  localparam int POR_QUAL_CYC    = (POR_QUAL_NS * (CLK_HZ / 1_000_000) + 999) / 1000;
  localparam int WD_TICK_MS      = 10;
  localparam int WD_TICK_CYC     = WD_TICK_MS * (CLK_HZ / 1000);
  localparam int RESET_PULSE_MS  = 20;
  localparam int RESET_PULSE_CYC = RESET_PULSE_MS * (CLK_HZ / 1000);

  // ==========================================================================
  // Serial frame
  // ==========================================================================
  localparam int FRAME_BITS = 16;

  typedef struct packed {
    logic       wr;
    logic [6:0] addr;
    logic [7:0] data;
  } psw_frame_t;

  // ==========================================================================
  // Register indices
  // ==========================================================================
  localparam logic [6:0] ADDR_CTRL1    = 7'h01;
  localparam logic [6:0] ADDR_WD_CFG   = 7'h02;
  localparam logic [6:0] ADDR_WD_CTRL  = 7'h03;
  localparam logic [6:0] ADDR_OUT_CTRL = 7'h04;
  localparam logic [6:0] ADDR_STATUS   = 7'h05;
  localparam logic [6:0] ADDR_SYS      = 7'h06;

  // ==========================================================================
  // Field positions and reset values
  // ==========================================================================
  localparam int CTRL1_SOFT_RESET_BIT = 0;
  localparam int CTRL1_POWER_HOLD_BIT = 1;
  localparam int CTRL1_SELF_TEST_BIT  = 6;
  localparam int WD_ENABLE_BIT        = 7;
  localparam int WD_REFRESH_BIT       = 7;
  localparam int STATUS_SPI_ERR_BIT   = 7;
  localparam int RELAY2_IDX           = 7;

  localparam logic [7:0] CTRL1_RESET    = 8'h00;
  localparam logic [7:0] WD_CFG_RESET   = 8'hca;
  localparam logic [7:0] WD_CTRL_RESET  = 8'h00;
  localparam logic [7:0] OUT_CTRL_RESET = 8'h00;
  localparam logic [7:0] STATUS_RESET   = 8'h00;
  localparam logic [7:0] RELAY2_MASK    = 8'h80;

  // ==========================================================================
  // States and supply group
  // ==========================================================================
  typedef enum logic [1:0] {
    PSW_SLEEP,
    PSW_QUALIFY,
    PSW_NORMAL,
    PSW_SHUTDOWN
  } psw_state_t;

  typedef struct packed {
    logic vpp;
    logic vcc;
    logic vprot;
  } psw_supply_t;

  // ==========================================================================
  // Helpers
  // ==========================================================================
  // Interval in 10 ms ticks: digit 1..10 times the largest selected multiplier
  function automatic logic [9:0] wd_ticks(input logic [6:0] field);
    logic [9:0] digit;
    digit = {6'h00, field[3:0]};
    if (field[3:0] == 4'h0) digit = 10'h001;
    else if (field[3:0] > 4'ha) digit = 10'h00a;
    if (field[6])      wd_ticks = 10'(digit * 10'd100);
    else if (field[5]) wd_ticks = 10'(digit * 10'd10);
    else               wd_ticks = digit;
  endfunction : wd_ticks

  function automatic logic addr_ok(input logic [6:0] addr);
    addr_ok = (addr >= ADDR_CTRL1) && (addr <= ADDR_SYS);
  endfunction : addr_ok

endpackage : psw_pkg

/* File: core/psw_wd_timer.sv */
// Watchdog down-counter clocked by a 10 ms tick strobe.
// Assumes reload, tick and enable come from logic on the same clock.
module psw_wd_timer
  import psw_pkg::*;
(
  // Clock and reset
  input  wire logic       clock,
  input  wire logic       rstN,
  // Control
  input  wire logic       tick,
  input  wire logic       enable,
  input  wire logic       reload,
  input  wire logic [9:0] loadTicks,
  // Result
  output logic            expired
);

  logic [9:0] count;

  // ==========================================================================
  // Countdown
  // ==========================================================================
  always_ff @(posedge clock or negedge rstN) begin
    if (!rstN) begin
      count   <= 10'h000;
      expired <= 1'b0;
    end else begin
      expired <= 1'b0;
      if (reload) begin
        count <= loadTicks;
      end else if (enable && tick && count != 10'h000) begin
        count <= count - 10'h001;
        if (count == 10'h001) begin
          expired <= 1'b1;
        end
      end
    end
  end

endmodule : psw_wd_timer

/* File: tb/psw_mcu_model.sv */
// MCU model: SPI master in mode 0 and the MCU end of the open-drain reset line.
// Assumes the 100 MHz system clock paces every serial edge; the bench calls the tasks.
module psw_mcu_model
  import psw_pkg::*;
(
  // Clock
  input  wire logic clock,
  // Serial port
  output logic      spiClk,
  output logic      spiCsN,
  output logic      spiDataIn,
  input  wire logic spiDataOut,
  input  wire logic spiDataOutOe,
  // Reset pin
  input  wire logic mcuResetOutput,
  input  wire logic mcuResetOutputOe
);
  timeunit 1ns;
  timeprecision 100ps;
  logic resetPin;
  logic miso;
  // Pulled up unless the supervisor sinks it
  assign resetPin = mcuResetOutputOe ? mcuResetOutput : 1'b1;
  // Released data line reads as the inverse of its last level
  assign miso = spiDataOutOe ? spiDataOut : ~spiDataOut;
  initial begin
    spiClk = 1'b0;
    spiCsN = 1'b1;
    spiDataIn = 1'b0;
  end
  // Idle data pattern changes every cycle
  always @(posedge clock) if (spiCsN) spiDataIn <= ~spiDataIn;
  // ==========
  // Transfers
  // ==========
  // An MCU held in reset does not talk
  task automatic xfer(input logic [15:0] tx, output logic [15:0] rx);
    int i;
    for (i = 0; i < 3000 && resetPin !== 1'b1; i++) @(posedge clock);
    if (resetPin !== 1'b1) psw_top_tb.errors++;
    spiCsN <= 1'b0;
    repeat (5) @(posedge clock);
    for (i = 15; i >= 0; i--) begin
      spiDataIn <= tx[i];
      repeat (4) @(posedge clock);
      spiClk <= 1'b1;
      rx[i] = miso;
      repeat (4) @(posedge clock);
      spiClk <= 1'b0;
    end
    repeat (4) @(posedge clock);
    spiCsN <= 1'b1;
    repeat (7) @(posedge clock);
  endtask : xfer
  task automatic refresh(input logic [7:0] t);
    logic [15:0] r;
    xfer({1'b1, ADDR_WD_CTRL, t | 8'h80}, r);
  endtask : refresh
endmodule : psw_mcu_model

/* File: tb/psw_top_sva.sv */
// Checker on the supervisor pins, bound into every psw_top.
// Assumes one clock domain and the top-level timer parameters.
module psw_top_sva
  import psw_pkg::*;
#(
  parameter int unsigned TICK_CYC  = WD_TICK_CYC,
  parameter int unsigned PULSE_CYC = RESET_PULSE_CYC
) (
  // Clock and reset
  input wire logic clock,
  input wire logic rst_n,
  // Power pins
  input wire logic keySwitchInput,
  input wire logic vccUndervoltage,
  input wire logic mainSupplyOvervoltage,
  // Serial port
  input wire logic spiClk,
  input wire logic spiCsN,
  input wire logic spiDataIn,
  input wire logic spiDataOut,
  input wire logic spiDataOutOe,
  // Requests and faults
  input wire logic [7:0] parallelInput,
  input wire logic [6:0] faultInput,
  // Driven outputs
  input wire logic [7:0] outputEnable,
  input wire psw_pkg::psw_supply_t supplyEnable,
  input wire logic batterySwitchOutput,
  input wire logic openLoadSinkEnable,
  // Reset pin
  input wire logic mcuResetOutput,
  input wire logic mcuResetOutputOe
);
  int unsigned lowCnt;
  int unsigned keyCnt;
  // Length of the current reset assertion
  always_ff @(posedge clock or negedge rst_n) begin
    if (!rst_n) lowCnt <= 0;
    else if (!mcuResetOutputOe) lowCnt <= 0;
    else if (lowCnt < 100000) lowCnt <= lowCnt + 1;
  end
  // Length of the current key-high stretch
  always_ff @(posedge clock or negedge rst_n) begin
    if (!rst_n) keyCnt <= 0;
    else if (!keySwitchInput) keyCnt <= 0;
    else if (keyCnt < 100000) keyCnt <= keyCnt + 1;
  end
  default clocking cb @(posedge clock); endclocking
  default disable iff (!rst_n);
  chk_pulse_len: assert property (
    $fell(mcuResetOutputOe) |-> lowCnt >= PULSE_CYC - 1) else $error("reset pulse short");
  chk_por_qual: assert property (
    $fell(mcuResetOutputOe) |-> keyCnt >= POR_QUAL_CYC) else $error("reset left early");
  chk_uv_reset: assert property (
    $rose(vccUndervoltage) |-> ##[1:6] mcuResetOutputOe) else $error("no undervoltage reset");
  chk_ov_reset: assert property (
    $rose(mainSupplyOvervoltage) |-> ##[1:6] mcuResetOutputOe) else $error("no overvoltage reset");
  chk_reset_outs: assert property (
    mcuResetOutputOe && $past(mcuResetOutputOe) |-> outputEnable == 8'h00)
    else $error("output on during reset");
  chk_sleep_off: assert property (
    supplyEnable == 3'b000 |-> outputEnable == 8'h00 && !openLoadSinkEnable
      && !batterySwitchOutput) else $error("sleep left something on");
  chk_key_low: assert property (
    !keySwitchInput [*5] |-> !batterySwitchOutput && (outputEnable & ~RELAY2_MASK) == 8'h00)
    else $error("output on with key low");
  chk_key_wake: assert property (
    $rose(keySwitchInput) |-> ##[1:6] supplyEnable == 3'b111) else $error("supplies not on");
  chk_pin_low: assert property (
    mcuResetOutputOe |-> mcuResetOutput == 1'b0) else $error("reset pin driven high");
  cover property ($fell(mcuResetOutputOe));
  cover property ($rose(mainSupplyOvervoltage));
  cover property (outputEnable == RELAY2_MASK && supplyEnable == 3'b111);
endmodule : psw_top_sva
bind psw_top psw_top_sva #(.TICK_CYC(TICK_CYC), .PULSE_CYC(PULSE_CYC)) i_sva (.clock, .rst_n,
  .keySwitchInput, .vccUndervoltage, .mainSupplyOvervoltage, .spiClk, .spiCsN, .spiDataIn,
  .spiDataOut, .spiDataOutOe, .parallelInput, .faultInput, .outputEnable, .supplyEnable,
  .batterySwitchOutput, .openLoadSinkEnable, .mcuResetOutput, .mcuResetOutputOe);

/* File: tb/psw_top_tb.sv */
// Bench for psw_top: drives power pins and faults, talks SPI through the MCU model.
// Assumes shortened tick and pulse parameters; expected times scale from them and from POR_QUAL_CYC.
module psw_top_tb;
  timeunit 1ns;
  timeprecision 100ps;
  import psw_pkg::*;
  localparam int TICK = 10;
  localparam int PULSE = 20;
  logic clock = 0, rst_n = 0, keySwitchInput = 0, vccUndervoltage = 0;
  logic mainSupplyOvervoltage = 0, spiClk, spiCsN, spiDataIn, spiDataOut, spiDataOutOe;
  logic [7:0] parallelInput = 0, outputEnable;
  logic [6:0] faultInput = 0;
  psw_supply_t supplyEnable;
  logic batterySwitchOutput, openLoadSinkEnable, mcuResetOutput, mcuResetOutputOe;
  int errors = 0, nChecks = 0;
  always #5 clock = ~clock;
  psw_top #(.TICK_CYC(TICK), .PULSE_CYC(PULSE)) i_dut (.clock, .rst_n, .keySwitchInput,
    .vccUndervoltage, .mainSupplyOvervoltage, .spiClk, .spiCsN, .spiDataIn, .spiDataOut,
    .spiDataOutOe, .parallelInput, .faultInput, .outputEnable, .supplyEnable,
    .batterySwitchOutput, .openLoadSinkEnable, .mcuResetOutput, .mcuResetOutputOe);
  psw_mcu_model i_mcu (.clock, .spiClk, .spiCsN, .spiDataIn, .spiDataOut, .spiDataOutOe,
    .mcuResetOutput, .mcuResetOutputOe);
  // ==========
  // Helpers
  // ==========
  task automatic stop_test();
    if (errors == 0 && nChecks > 0) $display("NO MISMATCHES");
    else $display("MISMATCHES SEEN");
    $finish;
  endtask : stop_test
  task automatic check(input logic [7:0] s, input logic [7:0] e);
    nChecks++;
    if (s !== e) begin
      errors++;
      $display("CHECK FAILED %0t got %h want %h", $time, s, e);
    end
  endtask : check
  task automatic inwin(input int n, input int lo, input int hi);
    check({7'h00, n >= lo && n <= hi}, 8'h01);
  endtask : inwin
  task automatic wait_oe(input logic v, input int lim, output int n);
    for (n = 0; mcuResetOutputOe !== v; n++) begin
      if (n >= lim) begin
        errors++;
        stop_test();
      end
      @(posedge clock);
    end
  endtask : wait_oe
  task automatic wr(input logic [6:0] a, input logic [7:0] d);
    logic [15:0] r;
    i_mcu.xfer({1'b1, a, d}, r);
  endtask : wr
  // The answer to a frame arrives in the next one
  task automatic rdchk(input logic [6:0] a, input logic [7:0] e);
    logic [15:0] r;
    i_mcu.xfer({1'b0, a, 8'h00}, r);
    i_mcu.xfer({1'b0, a, 8'h00}, r);
    check(r[7:0], e);
  endtask : rdchk
  // ==========
  // Scenarios
  // ==========
  task automatic t_sleep();
    check({5'h00, supplyEnable}, 8'h00);
    keySwitchInput <= 1'b1;
    repeat (100) @(posedge clock);
    keySwitchInput <= 1'b0;
    repeat (20) @(posedge clock);
    check({7'h00, mcuResetOutputOe}, 8'h01);
  endtask : t_sleep
  task automatic t_wake();
    int n;
    keySwitchInput <= 1'b1;
    wait_oe(1'b0, POR_QUAL_CYC + PULSE + 60, n);
    inwin(n, POR_QUAL_CYC + PULSE - 5, POR_QUAL_CYC + PULSE + 30);
    repeat (2) @(posedge clock);
    check({5'h00, supplyEnable}, 8'h07);
    check({batterySwitchOutput, openLoadSinkEnable}, 8'h03);
    check(outputEnable, 8'h00);
    rdchk(ADDR_WD_CFG, 8'hca);
    rdchk(ADDR_STATUS, STATUS_RESET);
  endtask : t_wake
  task automatic t_status();
    wr(7'h10, 8'h00);
    faultInput <= 7'h01;
    repeat (5) @(posedge clock);
    faultInput <= 7'h00;
    rdchk(ADDR_STATUS, 8'h81);
    wr(ADDR_STATUS, 8'h7e);
    rdchk(ADDR_STATUS, 8'h00);
    wr(ADDR_CTRL1, 8'h40);
    faultInput <= 7'h7f;
    wr(ADDR_STATUS, 8'h5a);
    rdchk(ADDR_STATUS, 8'h5a);
    faultInput <= 7'h00;
    wr(ADDR_CTRL1, 8'h00);
    rdchk(ADDR_STATUS, 8'h00);
  endtask : t_status
  task automatic t_wdog();
    logic [7:0] cfgT[7] = '{8'ha2, 8'ha0, 8'hb1, 8'haf, 8'he1, 8'h85, 8'ha5};
    logic [7:0] preT[7] = '{8'h00, 8'h00, 8'h00, 8'h00, 8'h00, 8'h00, 8'h22};
    int tkT[7] = '{20, 10, 10, 100, 100, 5, 20};
    int n;
    for (int i = 0; i < 7; i++) begin
      wr(ADDR_WD_CFG, cfgT[i]);
      if (preT[i] != 8'h00) wr(ADDR_WD_CTRL, preT[i]);
      i_mcu.refresh(8'h00);
      wait_oe(1'b1, tkT[i] * TICK + 40, n);
      inwin(n, tkT[i] * TICK - 15, tkT[i] * TICK + 10);
      wait_oe(1'b0, PULSE + 10, n);
    end
    rdchk(ADDR_WD_CFG, WD_CFG_RESET);
  endtask : t_wdog
  task automatic t_clear();
    int n;
    wr(ADDR_CTRL1, 8'h40);
    wr(ADDR_WD_CFG, 8'h22);
    i_mcu.refresh(8'h00);
    repeat (40 * TICK) @(posedge clock);
    check({7'h00, mcuResetOutputOe}, 8'h00);
    wr(ADDR_WD_CFG, 8'ha5);
    i_mcu.refresh(8'h22);
    repeat (5) @(posedge clock);
    i_mcu.refresh(8'h00);
    wait_oe(1'b1, 60 * TICK, n);
    inwin(n, 50 * TICK - 15, 50 * TICK + 10);
    wait_oe(1'b0, PULSE + 10, n);
    rdchk(ADDR_CTRL1, 8'h00);
  endtask : t_clear
  task automatic t_soft();
    logic seen;
    seen = 1'b0;
    wr(ADDR_WD_CFG, 8'h22);
    wr(ADDR_CTRL1, 8'h01);
    repeat (50) begin
      @(posedge clock);
      seen |= mcuResetOutputOe;
    end
    check({7'h00, seen}, 8'h00);
    rdchk(ADDR_WD_CFG, WD_CFG_RESET);
    rdchk(ADDR_CTRL1, CTRL1_RESET);
  endtask : t_soft
  task automatic t_volt();
    int n;
    for (int i = 0; i < 2; i++) begin
      if (i == 0) vccUndervoltage <= 1'b1;
      else mainSupplyOvervoltage <= 1'b1;
      repeat (4) @(posedge clock);
      vccUndervoltage <= 1'b0;
      mainSupplyOvervoltage <= 1'b0;
      wait_oe(1'b1, 10, n);
      wait_oe(1'b0, PULSE + 20, n);
      inwin(n, PULSE - 4, PULSE + 8);
    end
  endtask : t_volt
  task automatic t_keylow();
    wr(ADDR_OUT_CTRL, 8'h81);
    check(outputEnable, 8'h81);
    parallelInput <= 8'hff;
    wr(ADDR_CTRL1, 8'h02);
    check(outputEnable, 8'hff);
    keySwitchInput <= 1'b0;
    repeat (8) @(posedge clock);
    check(outputEnable, RELAY2_MASK);
    check({4'h0, batterySwitchOutput, supplyEnable}, 8'h07);
    wr(ADDR_CTRL1, 8'h00);
    check(outputEnable, 8'h00);
    check({4'h0, openLoadSinkEnable, supplyEnable}, 8'h00);
  endtask : t_keylow
  initial begin
    repeat (16) @(posedge clock);
    rst_n <= 1'b1;
    repeat (4) @(posedge clock);
    t_sleep();
    t_wake();
    t_status();
    t_wdog();
    t_clear();
    t_soft();
    t_volt();
    t_keylow();
    stop_test();
  end
  initial begin
    repeat (100000) @(posedge clock);
    errors++;
    stop_test();
  end
endmodule : psw_top_tb
